// >>> hub_irq_pkg.sv
package hub_irq_pkg;
  // ****************************************
  // register map: printed offsets are not multiples of four, so they are indices
  // ****************************************
  localparam logic [7:0] FORWARD_STATUS_IDX = 8'h22; // forwarding status
  localparam logic [7:0] IRQ_CONTROL_IDX = 8'h23; // interrupt control
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h24; // interrupt status
  localparam logic [7:0] SRC_CONFIG_IDX = 8'h30; // sync forward select
  localparam logic [7:0] EVT_STATUS_IDX = 8'h31; // sticky event status
  localparam logic [7:0] EVT_ENABLE_IDX = 8'h32; // event enable
  localparam logic [7:0] EVT_CLEAR_IDX = 8'h33; // event clear, write only
  // ****************************************
  // field positions
  // ****************************************
  localparam int SYNC_LOCKED_BIT = 0;
  localparam int SYNC_FAIL_BIT = 2;
  localparam int TX_IRQ_BIT = 4;
  localparam int GLOBAL_BIT = 7;
  localparam int SELECT_LSB = 2; // sync_forward_select field [3:2]
  localparam int NUM_RX = 4;
  localparam int NUM_EVT = 3; // lock gained, lock lost, sync failure
  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] FORWARD_STATUS_RST = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;
  localparam logic [7:0] IRQ_CONTROL_MASK = 8'h9F;
  localparam logic [1:0] SELECT_OFF = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_DECERR = 2'h3;
endpackage

// >>> hub_sticky_flag.sv
`timescale 1ns/1ns
// one sticky status bit; a set in the clearing cycle wins
module hub_sticky_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  typedef struct packed {
    logic flag;
  } state_s;
  state_s s_q, s_d;
  // set has priority so no event is lost
  always_comb begin
    s_d = s_q;
    if (clr_i) begin
      s_d.flag = 1'b0;
    end
    if (set_i) begin
      s_d.flag = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign flag_o = s_q.flag;
endmodule

// >>> hub_axil_slave.sv
`timescale 1ns/1ns
// minimal axi4-lite slave: one write and one read at a time, answer after both halves
module hub_axil_slave #(
  parameter int ADDR_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register-side strobes, one cycle each
  output logic wr_o,
  output logic [ADDR_W-3:0] wr_idx_o,
  output logic [7:0] wr_data_o,
  input wire logic wr_ok_i,
  output logic rd_o,
  output logic [ADDR_W-3:0] rd_idx_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_ok_i
);
  initial begin
    if (ADDR_W < 10) $error("ADDR_W too small for the register map");
  end
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-3:0] aw_idx;
    logic w_got;
    logic [7:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy; // address channel free, kept in a flop so the port comes straight from it
    logic w_rdy; // data channel free
    logic ar_rdy; // read channel free
  } state_s;
  state_s s_q, s_d;
  logic do_wr, do_rd;
  // write fires once both halves are held and no response is pending
  assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  // read fires the cycle the address is taken; the strobe clears the sync failure flag on a forwarding status read
  assign do_rd = s_axi_arvalid && !s_q.rvalid;
  always_comb begin
    s_d = s_q;
    if (s_axi_awvalid && !s_q.aw_got) begin
      s_d.aw_got = 1'b1;
      s_d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s_axi_wvalid && !s_q.w_got) begin
      s_d.w_got = 1'b1;
      // only lane 0 carries data; other lanes are ignored
      s_d.wdata = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
    end
    if (do_wr) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok_i ? hub_irq_pkg::AXI_OKAY : hub_irq_pkg::AXI_DECERR;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_data_i;
      s_d.rresp = rd_ok_i ? hub_irq_pkg::AXI_OKAY : hub_irq_pkg::AXI_DECERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    // ready flags follow the hold flags one edge ahead, so the ports need no gate
    s_d.aw_rdy = !s_d.aw_got;
    s_d.w_rdy = !s_d.w_got;
    s_d.ar_rdy = !s_d.rvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = {24'h000000, s_q.rdata};
  assign s_axi_rresp = s_q.rresp;
  assign wr_o = do_wr;
  assign wr_idx_o = s_q.aw_idx;
  assign wr_data_o = s_q.wdata;
  assign rd_o = do_rd;
  assign rd_idx_o = s_axi_araddr[ADDR_W-1:2];
endmodule

// >>> hub_irq_and_sync_status.sv
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module hub_irq_and_sync_status #(
  parameter int ADDR_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // forwarding engine status
  input wire logic engine_synced,
  input wire logic frame_sent,
  input wire logic sync_failed,
  // interrupt sources
  input wire logic [3:0] rx_event,
  input wire logic tx_event,
  input wire logic tx_event_register_read,
  input wire logic [3:0] rx_link_status_a_read,
  input wire logic [3:0] rx_link_status_b_read,
  input wire logic [3:0] rx_packet_status_read,
  // interrupt outputs
  output logic irq_out,
  output logic evt_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] irq_control; // enables and global enable
    logic [1:0] sync_forward_select; // forwarding mode field
    logic sync_locked_flag; // registered lock indication
    logic frame_seen; // a full synced frame went out
    logic [3:0] rx_read_a; // per-port read tracking
    logic [3:0] rx_read_b;
    logic [3:0] rx_read_p;
    logic [2:0] evt_enable; // event interrupt enables
    logic irq; // interrupt line to controller
    logic evt_irq; // event interrupt line
  } state_s;
  state_s s_q, s_d;

  // ****************************************
  // bus slave
  // ****************************************
  logic wr, rd;
  logic [ADDR_W-3:0] wr_idx, rd_idx;
  logic [7:0] wr_data, rd_data;
  logic wr_ok, rd_ok;
  hub_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_o(wr),
    .wr_idx_o(wr_idx),
    .wr_data_o(wr_data),
    .wr_ok_i(wr_ok),
    .rd_o(rd),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-3:0] idx, input logic [7:0] reg_idx);
    hit = (idx == (ADDR_W-2)'(reg_idx));
  endfunction

  logic sync_on; // sync forwarding selected
  assign sync_on = (s_q.sync_forward_select != hub_irq_pkg::SELECT_OFF);

  logic rd_fwd, rd_irq_sts, rd_evt;
  assign rd_fwd = rd && hit(rd_idx, hub_irq_pkg::FORWARD_STATUS_IDX);
  assign rd_irq_sts = rd && hit(rd_idx, hub_irq_pkg::IRQ_STATUS_IDX);
  assign rd_evt = rd && hit(rd_idx, hub_irq_pkg::EVT_STATUS_IDX);

  // ****************************************
  // sticky flags
  // ****************************************
  logic sync_fail_flag;
  logic [3:0] rx_flag;
  logic tx_irq_flag;
  logic [3:0] rx_clear;
  logic [2:0] evt_set, evt_flag, evt_clr;

  // failure only counts while synced forwarding runs and a frame has gone out
  hub_sticky_flag u_fail (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(sync_failed && sync_on && s_q.frame_seen),
    .clr_i(rd_fwd),
    .flag_o(sync_fail_flag)
  );

  hub_sticky_flag u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .set_i(tx_event),
    .clr_i(tx_event_register_read),
    .flag_o(tx_irq_flag)
  );

  // each port needs all three status registers read before its flag drops
  genvar g;
  generate
    for (g = 0; g < hub_irq_pkg::NUM_RX; g++) begin : g_rx
      assign rx_clear[g] = (s_q.rx_read_a[g] || rx_link_status_a_read[g])
                        && (s_q.rx_read_b[g] || rx_link_status_b_read[g])
                        && (s_q.rx_read_p[g] || rx_packet_status_read[g]);
      hub_sticky_flag u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_i(rx_event[g]),
        .clr_i(rx_clear[g]),
        .flag_o(rx_flag[g])
      );
    end
    for (g = 0; g < hub_irq_pkg::NUM_EVT; g++) begin : g_evt
      assign evt_clr[g] = wr && hit(wr_idx, hub_irq_pkg::EVT_CLEAR_IDX) && wr_data[g];
      hub_sticky_flag u_evt (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_i(evt_set[g]),
        .clr_i(evt_clr[g]),
        .flag_o(evt_flag[g])
      );
    end
  endgenerate

  // block events: lock gained, lock lost, failure recorded
  logic lock_now;
  assign lock_now = engine_synced && sync_on;
  assign evt_set = {sync_failed && sync_on && s_q.frame_seen,
                    s_q.sync_locked_flag && !lock_now,
                    !s_q.sync_locked_flag && lock_now};

  // ****************************************
  // pending and read mux
  // ****************************************
  logic [4:0] src_flags;
  logic pending;
  assign src_flags = {tx_irq_flag, rx_flag};
  // global enable deliberately absent from the pending term
  assign pending = |(src_flags & s_q.irq_control[4:0]);

  // reserved bits are tied to zero in every read value
  always_comb begin
    rd_data = 8'h00;
    rd_ok = 1'b1;
    if (hit(rd_idx, hub_irq_pkg::FORWARD_STATUS_IDX)) begin
      rd_data[hub_irq_pkg::SYNC_FAIL_BIT] = sync_fail_flag;
      rd_data[hub_irq_pkg::SYNC_LOCKED_BIT] = s_q.sync_locked_flag;
    end else if (hit(rd_idx, hub_irq_pkg::IRQ_CONTROL_IDX)) begin
      rd_data = s_q.irq_control;
    end else if (hit(rd_idx, hub_irq_pkg::IRQ_STATUS_IDX)) begin
      rd_data[hub_irq_pkg::GLOBAL_BIT] = pending;
      rd_data[4:0] = src_flags;
    end else if (hit(rd_idx, hub_irq_pkg::SRC_CONFIG_IDX)) begin
      rd_data[hub_irq_pkg::SELECT_LSB +: 2] = s_q.sync_forward_select;
    end else if (hit(rd_idx, hub_irq_pkg::EVT_STATUS_IDX)) begin
      rd_data[2:0] = evt_flag;
    end else if (hit(rd_idx, hub_irq_pkg::EVT_ENABLE_IDX)) begin
      rd_data[2:0] = s_q.evt_enable;
    end else if (hit(rd_idx, hub_irq_pkg::EVT_CLEAR_IDX)) begin
      rd_data = 8'h00; // write only
    end else begin
      rd_ok = 1'b0; // unmapped: decode error
    end
  end

  // writes to read-only registers are accepted and ignored
  always_comb begin
    wr_ok = hit(wr_idx, hub_irq_pkg::FORWARD_STATUS_IDX)
         || hit(wr_idx, hub_irq_pkg::IRQ_CONTROL_IDX)
         || hit(wr_idx, hub_irq_pkg::IRQ_STATUS_IDX)
         || hit(wr_idx, hub_irq_pkg::SRC_CONFIG_IDX)
         || hit(wr_idx, hub_irq_pkg::EVT_STATUS_IDX)
         || hit(wr_idx, hub_irq_pkg::EVT_ENABLE_IDX)
         || hit(wr_idx, hub_irq_pkg::EVT_CLEAR_IDX);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (wr && hit(wr_idx, hub_irq_pkg::IRQ_CONTROL_IDX)) begin
      s_d.irq_control = wr_data & hub_irq_pkg::IRQ_CONTROL_MASK;
    end
    if (wr && hit(wr_idx, hub_irq_pkg::SRC_CONFIG_IDX)) begin
      s_d.sync_forward_select = wr_data[hub_irq_pkg::SELECT_LSB +: 2];
    end
    if (wr && hit(wr_idx, hub_irq_pkg::EVT_ENABLE_IDX)) begin
      s_d.evt_enable = wr_data[2:0];
    end
    s_d.sync_locked_flag = lock_now;
    // first-frame history restarts whenever sync forwarding is off
    if (!sync_on) begin
      s_d.frame_seen = 1'b0;
    end else if (frame_sent) begin
      s_d.frame_seen = 1'b1;
    end
    // read tracking: remember reads until the flag clears, restart on new event
    for (int i = 0; i < hub_irq_pkg::NUM_RX; i++) begin
      if (rx_clear[i] || rx_event[i]) begin
        s_d.rx_read_a[i] = 1'b0;
        s_d.rx_read_b[i] = 1'b0;
        s_d.rx_read_p[i] = 1'b0;
      end else begin
        s_d.rx_read_a[i] = s_q.rx_read_a[i] | (rx_flag[i] & rx_link_status_a_read[i]);
        s_d.rx_read_b[i] = s_q.rx_read_b[i] | (rx_flag[i] & rx_link_status_b_read[i]);
        s_d.rx_read_p[i] = s_q.rx_read_p[i] | (rx_flag[i] & rx_packet_status_read[i]);
      end
    end
    s_d.irq = pending && s_q.irq_control[hub_irq_pkg::GLOBAL_BIT];
    s_d.evt_irq = |(evt_flag & s_q.evt_enable);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_out = s_q.irq;
  assign evt_irq = s_q.evt_irq;
endmodule

// >>> irq_host_model.sv
`timescale 1ns/1ns
// ****************************************
// host controller: samples the interrupt line at its input pin
// ****************************************
module irq_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_line,
  output logic irq_seen
);
  // one register stage, as a controller pin synchroniser adds; the bench allows for the lag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_seen <= 1'b0;
    end else begin
      irq_seen <= irq_line;
    end
  end
endmodule

// >>> hub_irq_properties.sv
`timescale 1ns/1ns
// ****************************************
// port-level checks of the status and interrupt block
// ****************************************
module hub_irq_checker #(
  parameter int ADDR_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic engine_synced,
  input wire logic frame_sent,
  input wire logic irq_out
);
  localparam logic [ADDR_W-1:0] FWD_A = ADDR_W'({hub_irq_pkg::FORWARD_STATUS_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] CTL_A = ADDR_W'({hub_irq_pkg::IRQ_CONTROL_IDX, 2'h0});
  localparam logic [ADDR_W-1:0] STS_A = ADDR_W'({hub_irq_pkg::IRQ_STATUS_IDX, 2'h0});
  logic [ADDR_W-1:0] rd_a_q; // address of the read in flight
  logic [ADDR_W-1:0] wr_a_q; // address of the write in flight
  logic [7:0] wr_d_q; // data of the write in flight
  logic glob_q; // shadow of the global enable, one cycle late
  logic seen_q; // a frame went out since reset
  logic bv_q; // response valid one cycle ago
  // shadow state rebuilt from bus traffic and frame_sent, so checks never peek inside
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_a_q <= '0;
      wr_a_q <= '0;
      wr_d_q <= 8'h00;
      glob_q <= 1'b0;
      seen_q <= 1'b0;
      bv_q <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_a_q <= s_axi_araddr;
      if (s_axi_awvalid && s_axi_awready) wr_a_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wr_d_q <= s_axi_wdata[7:0];
      if (frame_sent) seen_q <= 1'b1;
      bv_q <= s_axi_bvalid;
      // commit only when the response shows the register has taken the write
      if (s_axi_bvalid && !bv_q && wr_a_q == CTL_A) glob_q <= wr_d_q[7];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // first cycle of read data for a given register
  sequence answer_at(logic [ADDR_W-1:0] a);
    $rose(s_axi_rvalid) && rd_a_q == a;
  endsequence
  upper_bits_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  fwd_reserved_a: assert property (answer_at(FWD_A) |-> s_axi_rdata[7:3] == 5'h00 && !s_axi_rdata[1])
    else $error("forward status reserved bits set");
  fail_after_frame_a: assert property (answer_at(FWD_A) |-> !s_axi_rdata[2] || seen_q)
    else $error("sync failure reported before any frame");
  lock_source_a: assert property (answer_at(FWD_A) |-> !s_axi_rdata[0] || $past(engine_synced, 2))
    else $error("sync locked without synced engine");
  ctl_reserved_a: assert property (answer_at(CTL_A) |-> s_axi_rdata[6:5] == 2'h0)
    else $error("irq control reserved bits set");
  sts_reserved_a: assert property (answer_at(STS_A) |-> s_axi_rdata[6:5] == 2'h0)
    else $error("irq status reserved bits set");
  read_turn_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  irq_gate_a: assert property (irq_out |-> glob_q || $past(glob_q))
    else $error("interrupt line high with global enable off");
endmodule
bind hub_irq_and_sync_status hub_irq_checker #(.ADDR_W(ADDR_W)) u_hub_irq_checker (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .engine_synced, .frame_sent,
  .irq_out);

// >>> hub_irq_and_sync_status_test.sv
`timescale 1ns/1ns
module hub_irq_and_sync_status_test;
  // ****************************************
  // signals
  // ****************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, engine = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [19:0] pv = 20'h00000; // pulses: fail, frame, tx event, tx read, rx events, link a, link b, packet
  logic awready, wready, bvalid, arready, rvalid, irq_out, evt_irq, irq_seen;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int mismatches = 0, checks_done = 0, seed = 66;
  always #2 aclk = ~aclk;
  hub_irq_and_sync_status u_hub_irq_and_sync_status (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .engine_synced(engine), .frame_sent(pv[18]), .sync_failed(pv[19]), .rx_event(pv[15:12]), .tx_event(pv[17]),
    .tx_event_register_read(pv[16]), .rx_link_status_a_read(pv[11:8]), .rx_link_status_b_read(pv[7:4]),
    .rx_packet_status_read(pv[3:0]), .irq_out(irq_out), .evt_irq(evt_irq));
  irq_host_model u_irq_host_model (.aclk(aclk), .aresetn(aresetn), .irq_line(irq_out), .irq_seen(irq_seen));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [9:0] ba(input logic [7:0] idx);
    return {idx, 2'h0};
  endfunction
  // expected forwarding status: nothing shows while sync forwarding is off
  function automatic logic [7:0] fwd_exp(input logic [1:0] sel, input logic lock, input logic fail);
    return {5'h00, fail && sel != 2'h0, 1'b0, lock && sel != 2'h0};
  endfunction
  // expected irq status: pending ignores the global enable
  function automatic logic [7:0] sts_exp(input logic [4:0] st, input logic [7:0] ctl);
    return {|(st & ctl[4:0]), 2'h0, st};
  endfunction
  // write: both halves offered together, each dropped when taken, then wait for the response
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
    chk("write response", {6'h00, bresp}, {6'h00, hub_irq_pkg::AXI_OKAY});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    @(posedge aclk);
  endtask
  // one-cycle pulse on the side inputs, then a quiet cycle
  task automatic pulse(input logic [19:0] v);
    pv <= v;
    @(posedge aclk);
    pv <= 20'h00000;
    @(posedge aclk);
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] d, ctl, e;
    logic [4:0] st;
    logic [3:0] m;
    logic t;
    logic [1:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and an unmapped place
    for (int i = 0; i < 3; i++) begin
      rd(ba(hub_irq_pkg::FORWARD_STATUS_IDX + 8'(i)), d, r);
      chk("reset value", d, 8'h00);
    end
    rd(10'h3FC, d, r);
    chk("unmapped response", {6'h00, r}, {6'h00, hub_irq_pkg::AXI_DECERR});
    // every select code: failure before the first frame, after it, and read-clear
    for (int s = 0; s < 4; s++) begin
      engine <= (s == 0) ? 1'b1 : 1'($random(seed));
      wr(ba(hub_irq_pkg::SRC_CONFIG_IDX), 8'(s << 2));
      pulse(20'h80000);
      rd(ba(hub_irq_pkg::FORWARD_STATUS_IDX), d, r);
      chk("lock only", d, fwd_exp(2'(s), engine, 1'b0));
      pulse(20'h40000);
      pulse(20'h80000);
      rd(ba(hub_irq_pkg::FORWARD_STATUS_IDX), d, r);
      chk("sync failure", d, fwd_exp(2'(s), engine, 1'b1));
      rd(ba(hub_irq_pkg::FORWARD_STATUS_IDX), d, r);
      chk("failure cleared", d, fwd_exp(2'(s), engine, 1'b0));
      wr(ba(hub_irq_pkg::SRC_CONFIG_IDX), 8'h00);
    end
    // sources, enables, global gate and clearing; first two rounds are corner masks
    st = 5'h00;
    for (int i = 0; i < 10; i++) begin
      ctl = (i == 0) ? 8'h1F : (i == 1) ? 8'h80 : 8'($random(seed));
      wr(ba(hub_irq_pkg::IRQ_CONTROL_IDX), ctl);
      rd(ba(hub_irq_pkg::IRQ_CONTROL_IDX), d, r);
      chk("irq control", d, ctl & hub_irq_pkg::IRQ_CONTROL_MASK);
      m = 4'($random(seed));
      t = 1'($random(seed));
      pulse({2'h0, t, 1'b0, m, 12'h000});
      st = st | {t, m};
      wr(ba(hub_irq_pkg::IRQ_STATUS_IDX), 8'hFF); // read-only, must be ignored
      rd(ba(hub_irq_pkg::IRQ_STATUS_IDX), d, r);
      e = sts_exp(st, ctl);
      chk("irq status", d, e);
      chk("irq line", {7'h00, irq_out}, {7'h00, e[7] & ctl[7]});
      chk("host view", {7'h00, irq_seen}, {7'h00, e[7] & ctl[7]});
      m = 4'($random(seed));
      t = 1'($random(seed));
      pulse({8'h00, m, m, 4'h0});
      rd(ba(hub_irq_pkg::IRQ_STATUS_IDX), d, r);
      chk("rx flags held", d, e);
      pulse({3'h0, t, 4'h0, 8'h00, m});
      st = st & ~{t, m};
    end
    // event interrupt: raise, mask, unmask, clear
    wr(ba(hub_irq_pkg::EVT_CLEAR_IDX), 8'h07);
    wr(ba(hub_irq_pkg::EVT_ENABLE_IDX), 8'h04);
    wr(ba(hub_irq_pkg::SRC_CONFIG_IDX), 8'h04);
    pulse(20'h40000);
    pulse(20'h80000);
    rd(ba(hub_irq_pkg::EVT_STATUS_IDX), d, r);
    chk("event failure", d & 8'h04, 8'h04);
    chk("event irq", {7'h00, evt_irq}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(ba((k == 2) ? hub_irq_pkg::EVT_CLEAR_IDX : hub_irq_pkg::EVT_ENABLE_IDX), (k == 1) ? 8'h04 : 8'h00);
      if (k == 2) wr(ba(hub_irq_pkg::EVT_CLEAR_IDX), 8'h04);
      repeat (3) @(posedge aclk);
      chk("event irq step", {7'h00, evt_irq}, {7'h00, k == 1});
    end
    report_and_stop;
  end
endmodule
